// [core/caf_top.sv]
// Top of the CAN acceptance filter and bit-rate prescaler with AHB-Lite registers
// Operation
// RL1: Match register accessible only during reset request
// RL2: Ignore register accessible only during reset request
// RL3: Store descriptor then data in empty buffer
// RL4: No empty buffer on acceptance sets overflow
// RL5: Correct complete frame sets buffer full
// RL6: Complete frame sets receive event if enabled
// RL7: Own transmitted frame filtered and stored too
// RL8: Own transmission overflow when no buffer free
// RL9: Accept when id matches or ignored, all bits
// RL10: Ignore bit one means don't care
// RL11: Resynchronise on each relevant bus edge
// RL12: Resync jump at most field plus one quanta
// RL13: Quantum is two clocks times divider plus one
// RL14: Overflow event set with overflow when enabled
// RL15: Release command clears full; new frame sets again
`timescale 1ns/100ps
module caf_top
   import caf_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic frameStart,
   input wire logic [7:0] frameIdHigh,
   input wire logic frameByteValid,
   input wire logic [7:0] frameByte,
   input wire logic frameDone,
   input wire logic frameError,
   input wire logic [4:0] phaseErr,
   input wire logic phaseLate,
   input wire logic resyncEdge,
   input wire logic [3:0] rxReadIndex,
   output logic [7:0] rxReadData,
   output logic frameAccepted,
   output logic quantumTick,
   output logic [2:0] jumpApplied,
   output logic jumpLate,
   output logic irq
);
   import caf_pkg::*;
   // ***********************************
   // Register state
   // ***********************************
   logic [7:0] matchPattern;
   logic [7:0] ignoreSelect;
   logic [7:0] bitTiming;
   logic [7:0] ctrl;
   logic [1:0] irqStatus;
   logic [1:0] irqMask;
   logic dataOverrun;
   logic freeRx;
   logic clrOvr;
   logic dphWrite;
   logic dphRead;
   logic [3:0] dphIndex;
   logic anyFull;
   logic overrunPulse;
   logic storedPulse;
   caf_frame_if frm();
   // Frame stream onto the internal carrier
   assign frm.start = frameStart;
   assign frm.idHigh = frameIdHigh;
   assign frm.byteValid = frameByteValid;
   assign frm.byteData = frameByte;
   assign frm.done = frameDone;
   assign frm.error = frameError;
   // ***********************************
   // Acceptance test
   // ***********************************
   // Each bit passes if equal or ignored; all eight must pass
   function automatic logic passFilter(input logic [7:0] id, input logic [7:0] code, input logic [7:0] ign);
      passFilter = &(~(id ^ code) | ign); // see RL9 see RL10
   endfunction
   wire acceptNow = passFilter(frm.idHigh, matchPattern, ignoreSelect);
   // Accepted-frame strobe for the rest of the controller
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         frameAccepted <= 1'b0;
      end else if (ce) begin
         frameAccepted <= frm.start && acceptNow; // see RL7
      end
   end
   // ***********************************
   // Bus slave decode
   // ***********************************
   wire addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;
   wire [3:0] addrIndex = haddr[ADDR_LSB+3:ADDR_LSB];
   wire inReset = ctrl[CTRL_RST_REQ];
   wire cfgIndex = dphIndex == IDX_MATCH || dphIndex == IDX_IGNORE || dphIndex == IDX_TIMING;
   wire cfgOpen = !cfgIndex || inReset; // see RL1 see RL2
   wire wrEn = dphWrite && cfgOpen;
   wire wrMatch = wrEn && dphIndex == IDX_MATCH;
   wire wrIgnore = wrEn && dphIndex == IDX_IGNORE;
   wire wrTiming = wrEn && dphIndex == IDX_TIMING;
   wire wrCtrl = wrEn && dphIndex == IDX_CTRL;
   wire wrIrq = wrEn && dphIndex == IDX_IRQ;
   wire wrMask = wrEn && dphIndex == IDX_MASK;
   wire wrCmd = wrEn && dphIndex == IDX_CMD;
   // Zero-wait slave: every access completes in its first data cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // Capture the address phase
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dphWrite <= 1'b0;
         dphRead <= 1'b0;
         dphIndex <= 4'h0;
      end else if (ce) begin
         dphWrite <= addrPhase && hwrite;
         dphRead <= addrPhase && !hwrite;
         dphIndex <= addrIndex;
      end
   end
   // ***********************************
   // Register writes
   // ***********************************
   // Configuration and control registers; match, ignore and timing writes outside reset request are dropped
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         matchPattern <= CFG_RESET;
         ignoreSelect <= CFG_RESET;
         bitTiming <= CFG_RESET;
         ctrl <= CTRL_RESET;
         irqMask <= 2'h0;
      end else if (ce) begin
         if (wrMatch) matchPattern <= hwdata[7:0]; // see RL1
         if (wrIgnore) ignoreSelect <= hwdata[7:0]; // see RL2
         if (wrTiming) bitTiming <= hwdata[7:0];
         if (wrCtrl) ctrl <= hwdata[7:0];
         if (wrMask) irqMask <= hwdata[1:0];
      end
   end
   // Command bits are one-cycle pulses, never stored
   assign freeRx = wrCmd && hwdata[CMD_FREE_RX];
   assign clrOvr = wrCmd && hwdata[CMD_CLR_OVR];
   // Sticky events; a new event wins over a write-one clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irqStatus <= 2'h0;
         dataOverrun <= 1'b0;
      end else if (ce) begin
         irqStatus[IRQ_RX] <= (storedPulse && ctrl[CTRL_RX_IE]) // see RL6
            || (irqStatus[IRQ_RX] && !(wrIrq && hwdata[IRQ_RX]));
         irqStatus[IRQ_OVR] <= (overrunPulse && ctrl[CTRL_OVR_IE]) // see RL14
            || (irqStatus[IRQ_OVR] && !(wrIrq && hwdata[IRQ_OVR]));
         dataOverrun <= overrunPulse || (dataOverrun && !clrOvr); // see RL4
      end
   end
   assign irq = |(irqStatus & irqMask);
   // ***********************************
   // Register reads
   // ***********************************
   // Locked configuration reads as zero outside reset request
   wire [7:0] cfgView = !cfgOpen ? 8'h00 :
      dphIndex == IDX_MATCH ? matchPattern :
      dphIndex == IDX_IGNORE ? ignoreSelect : bitTiming;
   wire [7:0] stView = {6'h00, dataOverrun, anyFull};
   wire [7:0] readByte = cfgIndex ? cfgView :
      dphIndex == IDX_CTRL ? ctrl :
      dphIndex == IDX_STATUS ? stView :
      dphIndex == IDX_IRQ ? {6'h00, irqStatus} :
      dphIndex == IDX_MASK ? {6'h00, irqMask} : 8'h00;
   assign hrdata = dphRead ? {24'h000000, readByte} : 32'h00000000;
   // ***********************************
   // Sub-blocks
   // ***********************************
   caf_rx_store store (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .frame(frm.dst),
      .accept(acceptNow),
      .freeBuf(freeRx),
      .rdIndex(rxReadIndex),
      .rdData(rxReadData),
      .anyFull(anyFull),
      .overrun(overrunPulse),
      .storedPulse(storedPulse)
   );
   caf_prescaler presc (
      .clk(clk),
      .rstn(rstn),
      .ce(ce),
      .run(!inReset),
      .divider(bitTiming[5:0]),
      .jumpField(bitTiming[7:6]),
      .phaseErr(phaseErr),
      .phaseLate(phaseLate),
      .resyncEdge(resyncEdge),
      .quantumTick(quantumTick),
      .jumpApplied(jumpApplied),
      .jumpLate(jumpLate)
   );
endmodule

// [core/caf_pkg.sv]
// Package of constants and types for the CAN acceptance filter and bit timing block
package caf_pkg;
   // ***********************************
   // Register indices; the byte address is index * 4
   // ***********************************
   localparam logic [3:0] IDX_MATCH = 4'h4;
   localparam logic [3:0] IDX_IGNORE = 4'h5;
   localparam logic [3:0] IDX_TIMING = 4'h6;
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_STATUS = 4'h1;
   localparam logic [3:0] IDX_IRQ = 4'h2;
   localparam logic [3:0] IDX_MASK = 4'h3;
   localparam logic [3:0] IDX_CMD = 4'h8;
   localparam int ADDR_LSB = 2;
   // ***********************************
   // Field positions and reset values
   // ***********************************
   localparam int CTRL_RST_REQ = 0;
   localparam int CTRL_RX_IE = 1;
   localparam int CTRL_OVR_IE = 2;
   localparam int CMD_FREE_RX = 0;
   localparam int CMD_CLR_OVR = 1;
   localparam int ST_FULL = 0;
   localparam int ST_OVR = 1;
   localparam int IRQ_RX = 0;
   localparam int IRQ_OVR = 1;
   localparam logic [7:0] CTRL_RESET = 8'h01;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam int NUM_BUFS = 2;
   localparam int BUF_BYTES = 10;
   localparam int DESC_BYTES = 2;
   localparam logic [3:0] BYTE_MAX = 4'h9;
   localparam logic [3:0] DLC_MAX = 4'h8;
   typedef enum logic [2:0] {
      RX_IDLE = 3'b001,
      RX_STORE = 3'b010,
      RX_DROP = 3'b100
   } caf_rx_state_t;
endpackage

// [core/caf_frame_if.sv]
// Interface carrying the frame byte stream from the bitstream side to the filter
`timescale 1ns/100ps
interface caf_frame_if;
   logic start;
   logic [7:0] idHigh;
   logic byteValid;
   logic [7:0] byteData;
   logic done;
   logic error;
   modport src (output start, idHigh, byteValid, byteData, done, error);
   modport dst (input start, idHigh, byteValid, byteData, done, error);
endinterface

// [core/caf_prescaler.sv]
// Time-quantum prescaler with resynchronisation jump limit
`timescale 1ns/100ps
module caf_prescaler
   import caf_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic run,
   input wire logic [5:0] divider,
   input wire logic [1:0] jumpField,
   input wire logic [4:0] phaseErr,
   input wire logic phaseLate,
   input wire logic resyncEdge,
   output logic quantumTick,
   output logic [2:0] jumpApplied,
   output logic jumpLate
);
   import caf_pkg::*;
   logic [6:0] count;
   logic [2:0] limit;
   logic [2:0] errClip;
   wire [6:0] terminal = {divider, 1'b1}; // 2 * (divider + 1) - 1 clock cycles
   // Jump is the smaller of phase error and jump limit + 1
   assign limit = {1'b0, jumpField} + 3'h1;
   assign errClip = (phaseErr > {2'h0, limit}) ? limit : phaseErr[2:0];
   // Counter restarts when stopped so the first quantum has full length
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         count <= 7'h00;
         quantumTick <= 1'b0;
      end else if (ce) begin
         quantumTick <= run && (count == terminal); // see RL13
         count <= (!run || count == terminal) ? 7'h00 : count + 7'h01;
      end
   end
   // Resync result is registered for the segment logic downstream
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         jumpApplied <= 3'h0;
         jumpLate <= 1'b0;
      end else if (ce && resyncEdge) begin
         jumpApplied <= errClip; // see RL11 see RL12
         jumpLate <= phaseLate;
      end
   end
endmodule

// [core/caf_rx_store.sv]
// Receive buffer store: two frame buffers written by accepted frames
`timescale 1ns/100ps
module caf_rx_store
   import caf_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   caf_frame_if.dst frame,
   input wire logic accept,
   input wire logic freeBuf,
   input wire logic [3:0] rdIndex,
   output logic [7:0] rdData,
   output logic anyFull,
   output logic overrun,
   output logic storedPulse
);
   import caf_pkg::*;
   caf_rx_state_t state;
   caf_rx_state_t next_state;
   logic [7:0] mem [NUM_BUFS][BUF_BYTES];
   logic [NUM_BUFS-1:0] full;
   logic wrBuf;
   logic rdBuf;
   logic [3:0] wrPtr;
   wire freeSlot = !full[0] || !full[1];
   wire pickBuf = full[0] ? 1'b1 : 1'b0;
   wire startKeep = frame.start && accept && freeSlot;
   // Frame sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         RX_IDLE: if (frame.start) next_state = startKeep ? RX_STORE : RX_DROP;
         RX_STORE: if (frame.done || frame.error) next_state = RX_IDLE;
         RX_DROP: if (frame.done || frame.error) next_state = RX_IDLE;
         default: next_state = RX_IDLE;
      endcase
   end
   // Descriptor first, then data, into the chosen empty buffer
   always_ff @(posedge clk) begin
      if (ce && state == RX_STORE && frame.byteValid && wrPtr <= BYTE_MAX) begin
         mem[wrBuf][wrPtr] <= frame.byteData; // see RL3 see RL7
      end
   end
   // Pointers, full flags; a store wins over a release in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= RX_IDLE;
         full <= '0;
         wrBuf <= 1'b0;
         rdBuf <= 1'b0;
         wrPtr <= 4'h0;
         overrun <= 1'b0;
         storedPulse <= 1'b0;
      end else if (ce) begin
         state <= next_state;
         overrun <= frame.start && accept && !freeSlot; // see RL4 see RL8
         storedPulse <= state == RX_STORE && frame.done && !frame.error;
         if (startKeep) begin
            wrBuf <= pickBuf;
            wrPtr <= 4'h0;
         end else if (state == RX_STORE && frame.byteValid && wrPtr <= BYTE_MAX) begin
            wrPtr <= wrPtr + 4'h1;
         end
         if (freeBuf && full[rdBuf]) begin
            full[rdBuf] <= 1'b0; // see RL15
            rdBuf <= !rdBuf;
         end
         if (state == RX_STORE && frame.done && !frame.error) begin
            full[wrBuf] <= 1'b1; // see RL5
         end
      end
   end
   // Software reads the buffer at the read pointer, which flips to the other buffer on each release of a full buffer
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdData <= 8'h00;
      end else if (ce) begin
         rdData <= (rdIndex <= BYTE_MAX) ? mem[rdBuf][rdIndex] : 8'h00;
      end
   end
   assign anyFull = |full;
endmodule

// [test/caf_node_model.sv]
// Behavioural model of another bus node feeding frames to the filter
`timescale 1ns/100ps
module caf_node_model (
   input wire logic clk,
   output logic frameStart,
   output logic [7:0] frameIdHigh,
   output logic frameByteValid,
   output logic [7:0] frameByte,
   output logic frameDone,
   output logic frameError
);
   // Idle at time zero; stale lanes are inverted later so no old value lingers
   initial begin
      {frameStart, frameIdHigh, frameByteValid, frameByte, frameDone, frameError} = '0;
   end
   // Descriptor then data bytes in order, byte i = id xor i; slow adds gaps
   task automatic send(input logic [7:0] id, input int n, input logic bad, input logic slow);
      frameStart <= 1'b1;
      frameIdHigh <= id;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         {frameStart, frameIdHigh, frameByteValid} <= {1'b0, ~id, 1'b1};
         frameByte <= id ^ i[7:0];
         if (slow) begin
            @(posedge clk);
            {frameByteValid, frameByte} <= {1'b0, ~(id ^ i[7:0])};
         end
      end
      @(posedge clk);
      {frameStart, frameIdHigh, frameByteValid, frameByte} <= {1'b0, ~id, 1'b0, ~frameByte};
      {frameDone, frameError} <= {1'b1, bad};
      @(posedge clk);
      {frameDone, frameError} <= 2'b00;
   endtask
endmodule

// [test/caf_checker.sv]
// Assertion checker bound to the filter top ports
`timescale 1ns/100ps
module caf_checker
   import caf_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic frameStart,
   input wire logic [7:0] frameIdHigh,
   input wire logic frameAccepted,
   input wire logic [4:0] phaseErr,
   input wire logic phaseLate,
   input wire logic resyncEdge,
   input wire logic [2:0] jumpApplied,
   input wire logic jumpLate,
   input wire logic quantumTick
);
   import caf_pkg::*;
   logic wrPend, rdPend, rr, seen;
   logic [7:0] pAddr, mt, ig, tm, cnt;
   // Expected filter, jump and quantum figures from the shadow registers
   wire logic take = hsel && hready && htrans == HTRANS_NONSEQ;
   wire logic [2:0] lim = {1'b0, tm[7:6]} + 3'h1;
   wire logic [2:0] jumpExp = (phaseErr < {2'b00, lim}) ? phaseErr[2:0] : lim;
   wire logic pass = &(~(frameIdHigh ^ mt) | ig);
   wire logic [7:0] period = {1'b0, tm[5:0], 1'b0} + 8'h02;
   // Shadow copies; config lands only while reset request is set
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         {wrPend, rdPend, seen, pAddr, cnt} <= '0;
         rr <= CTRL_RESET[CTRL_RST_REQ];
         {mt, ig, tm} <= {3{CFG_RESET}};
      end else begin
         {wrPend, rdPend, pAddr} <= {take && hwrite, take && !hwrite, haddr[7:0]};
         cnt <= quantumTick ? 8'h01 : cnt + 8'h01;
         seen <= !rr && (quantumTick || seen);
         if (wrPend && pAddr == 8'h00) rr <= hwdata[CTRL_RST_REQ];
         if (wrPend && rr && pAddr == 8'h10) mt <= hwdata[7:0];
         if (wrPend && rr && pAddr == 8'h14) ig <= hwdata[7:0];
         if (wrPend && rr && pAddr == 8'h18) tm <= hwdata[7:0];
      end
   end
   // ***********
   // Assertions
   // ***********
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_accept; frameStart && !rr && pass |=> frameAccepted; endproperty
   a_accept: assert property (p_accept) else $error("passing id not accepted");
   property p_reject; frameStart && !pass |=> !frameAccepted; endproperty
   a_reject: assert property (p_reject) else $error("failing id accepted");
   property p_jump; resyncEdge |=> jumpApplied == $past(jumpExp); endproperty
   a_jump: assert property (p_jump) else $error("jump not limited");
   property p_jump_dir; resyncEdge |=> jumpLate == $past(phaseLate); endproperty
   a_jump_dir: assert property (p_jump_dir) else $error("jump direction wrong");
   property p_quantum; quantumTick && seen |-> cnt == period; endproperty
   a_quantum: assert property (p_quantum) else $error("quantum length wrong");
   property p_no_tick; rr && $past(rr) && $past(rr, 2) |-> !quantumTick; endproperty
   a_no_tick: assert property (p_no_tick) else $error("tick during reset request");
   property p_match_rd; rdPend && pAddr == 8'h10 |-> hrdata == (rr ? {24'h0, mt} : 32'h0); endproperty
   a_match_rd: assert property (p_match_rd) else $error("match read wrong");
   property p_ignore_rd; rdPend && pAddr == 8'h14 |-> hrdata == (rr ? {24'h0, ig} : 32'h0); endproperty
   a_ignore_rd: assert property (p_ignore_rd) else $error("ignore read wrong");
   c_accept: cover property (frameAccepted);
   c_resync: cover property (resyncEdge && phaseErr > 5'h4);
   c_tick: cover property (quantumTick && seen);
endmodule
bind caf_top caf_checker caf_checker_inst (.clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
   .hrdata, .frameStart, .frameIdHigh, .frameAccepted, .phaseErr, .phaseLate, .resyncEdge, .jumpApplied,
   .jumpLate, .quantumTick);

// [test/tb_can_accept_filter_bit_timing.sv]
// Self-checking bench for the acceptance filter and bit timing block
`timescale 1ns/100ps
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin errCount++; $display("Error at %0t: got %h want %h", $time, g, e); end end
module tb_can_accept_filter_bit_timing;
   import caf_pkg::*;
   logic clk, rstn, hwrite, phaseLate, resyncEdge;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, rdv;
   logic [4:0] phaseErr;
   logic [3:0] rxReadIndex;
   wire logic [31:0] hrdata;
   wire logic hreadyout, hresp, frameStart, frameByteValid, frameDone, frameError;
   wire logic frameAccepted, quantumTick, jumpLate, irq;
   wire logic [7:0] frameIdHigh, frameByte, rxReadData;
   wire logic [2:0] jumpApplied;
   int errCount = 0, nChecks = 0, accCnt = 0, gap;
   caf_top caf_top_inst (.clk, .rstn, .ce(1'b1), .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .frameStart, .frameIdHigh, .frameByteValid,
      .frameByte, .frameDone, .frameError, .phaseErr, .phaseLate, .resyncEdge, .rxReadIndex, .rxReadData,
      .frameAccepted, .quantumTick, .jumpApplied, .jumpLate, .irq);
   caf_node_model caf_node_model_inst (.clk, .frameStart, .frameIdHigh, .frameByteValid, .frameByte,
      .frameDone, .frameError);
   // Clock, hang guard and accepted-frame count
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      errCount++;
      $display("Error at %0t: run hung", $time);
      tallyAndFinish();
   end
   always @(posedge clk) if (frameAccepted === 1'b1) accCnt++;
   task automatic tallyAndFinish();
      $display("Checks %0d, errors %0d", nChecks, errCount);
      if (errCount == 0 && nChecks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Waits are bounded: a silent slave ends the run rather than hanging it
   task automatic waitReady();
      int k;
      for (k = 0; k < 16; k++) begin
         @(posedge clk);
         if (hreadyout === 1'b1) break;
      end
      if (k == 16) begin
         errCount++;
         $display("Error at %0t: bus hang", $time);
         tallyAndFinish();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      {htrans, hwrite, haddr} <= {HTRANS_NONSEQ, w, 24'h0, a};
      waitReady();
      {htrans, hwdata} <= {2'h0, d};
      waitReady();
      rdv = hrdata;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK(rdv, e)
      `CHK(hresp, 1'b0)
   endtask
   task automatic pin(input logic e);
      @(negedge clk);
      `CHK(irq, e)
      @(posedge clk);
   endtask
   task automatic resync(input logic [4:0] e, input logic l, input logic [2:0] j);
      {phaseErr, phaseLate, resyncEdge} <= {e, l, 1'b1};
      @(posedge clk) resyncEdge <= 1'b0;
      @(posedge clk);
      `CHK(jumpApplied, j)
      `CHK(jumpLate, l)
   endtask
   task automatic frame(input logic [7:0] id, input int n, input logic bad, input logic [31:0] st);
      caf_node_model_inst.send(id, n, bad, n > 4);
      repeat (2) @(posedge clk);
      rdChk(8'h04, st);
   endtask
   task automatic rxByte(input logic [3:0] i, input logic [7:0] e);
      rxReadIndex <= i;
      repeat (2) @(posedge clk);
      `CHK(rxReadData, e)
   endtask
   // Main sequence: config, timing, filtering, storage, overrun, release
   initial begin
      {rstn, htrans, hwrite, haddr, hwdata, phaseErr, phaseLate, resyncEdge, rxReadIndex} = '0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      rdChk(8'h00, 32'h1);
      bus(1'b1, 8'h10, 32'ha5);
      bus(1'b1, 8'h14, 32'h0f);
      bus(1'b1, 8'h18, 32'h42);
      rdChk(8'h10, 32'ha5);
      rdChk(8'h14, 32'h0f);
      rdChk(8'h3c, 32'h0);
      bus(1'b1, 8'h0c, 32'h3);
      bus(1'b1, 8'h00, 32'h6);
      bus(1'b1, 8'h14, 32'hff);
      rdChk(8'h14, 32'h0);
      tickGap: begin
         for (int k = 0; k < 300 && quantumTick !== 1'b1; k++) @(posedge clk);
         gap = 0;
         do begin @(posedge clk); gap++; end while (quantumTick !== 1'b1 && gap < 300);
      end
      `CHK(gap, 6)
      resync(5'd5, 1'b1, 3'h2);
      resync(5'd1, 1'b0, 3'h1);
      resync(5'd2, 1'b1, 3'h2);
      frame(8'h5a, 3, 1'b0, 32'h0);
      `CHK(accCnt, 0)
      frame(8'ha3, 3, 1'b1, 32'h0);
      rdChk(8'h08, 32'h0);
      frame(8'hac, 6, 1'b0, 32'h1);
      `CHK(accCnt, 2)
      rdChk(8'h08, 32'h1);
      pin(1'b1);
      for (int i = 0; i < 6; i++) rxByte(i[3:0], 8'hac ^ i[7:0]);
      bus(1'b1, 8'h08, 32'h1);
      pin(1'b0);
      frame(8'haf, 2, 1'b0, 32'h1);
      frame(8'ha0, 1, 1'b0, 32'h3);
      rdChk(8'h08, 32'h3);
      pin(1'b1);
      bus(1'b1, 8'h0c, 32'h0);
      pin(1'b0);
      bus(1'b1, 8'h20, 32'h1);
      rdChk(8'h04, 32'h3);
      rxByte(4'h1, 8'hae);
      bus(1'b1, 8'h20, 32'h1);
      bus(1'b1, 8'h20, 32'h2);
      rdChk(8'h04, 32'h0);
      frame(8'ha1, 1, 1'b0, 32'h1);
      tallyAndFinish();
   end
endmodule
